// ===== design/hub_consts.vh
`ifndef HUB_CONSTS_VH
`define HUB_CONSTS_VH

// clock and derived timing
`define CLK_MHZ           125
`define PORT_RESET_US     10000
`define PORT_RESET_CYC    (`PORT_RESET_US * `CLK_MHZ)
`define CHIRP_US          1000
`define CHIRP_CYC         (`CHIRP_US * `CLK_MHZ)
`define SPI_DIV           8

// serial memory access
`define MEM_READ_CMD      8'h03
`define MEM_START_ADDR    8'h00
`define MEM_HDR_BITS      16
`define MEM_CFG_BYTES     8
`define LOAD_EXT_A        8'hd2
`define LOAD_EXT_B        8'hd4

// configuration byte positions within the loaded image
`define CFG_CODE          0
`define CFG_VID_LO        1
`define CFG_VID_HI        2
`define CFG_PID_LO        3
`define CFG_PID_HI        4
`define CFG_DID_LO        5
`define CFG_DID_HI        6
`define CFG_PORTS         7
`define CFG_PORTS_RST     8'h00

// host request codes
`define REQ_SET_ADDR      4'h1
`define REQ_SET_CONFIG    4'h2
`define REQ_SET_POWER     4'h3
`define REQ_CLR_POWER     4'h4
`define REQ_SET_RESET     4'h5
`define REQ_CLR_ENABLE    4'h6
`define REQ_SET_SUSPEND   4'h7
`define REQ_CLR_SUSPEND   4'h8
`define REQ_IND_MANUAL    4'h9
`define REQ_IND_AUTO      4'ha

// change bits reported per port
`define CHG_CONNECT       0
`define CHG_ENABLE        1
`define CHG_SUSPEND       2
`define CHG_RESET         3

// token identification
`define PID_TOKEN_OUT     4'h1
`define PID_TOKEN_IN      4'h9
`define PID_TOKEN_SETUP   4'hd

`endif

// ===== design/change_buffer.v
`timescale 1ns/1ns
module change_buffer #(
  parameter WIDTH = 8
) (
  input  wire             clock_i,
  input  wire             rst_n_i,
  input  wire             in_valid_i,
  output wire             in_ready_o,
  input  wire [WIDTH-1:0] in_data_i,
  output wire             out_valid_o,
  input  wire             out_ready_i,
  output reg  [WIDTH-1:0] out_data_o
);
  // two entries: head drives the port from a flop, tail catches a stall
  reg [WIDTH-1:0] tail_q;
  reg             head_v_q;
  reg             tail_v_q;
  wire            push;
  wire            pop;

  assign in_ready_o  = ~tail_v_q;
  assign out_valid_o = head_v_q;
  assign push        = in_valid_i & ~tail_v_q;
  assign pop         = head_v_q & out_ready_i;

  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      head_v_q   <= 1'b0;
      tail_v_q   <= 1'b0;
      out_data_o <= {WIDTH{1'b0}};
      tail_q     <= {WIDTH{1'b0}};
    end else begin
      if (pop) begin
        if (tail_v_q) begin
          out_data_o <= tail_q;
          tail_v_q   <= 1'b0;
          if (push) begin
            tail_q   <= in_data_i;
            tail_v_q <= 1'b1;
          end
        end else if (push) begin
          out_data_o <= in_data_i;
        end else begin
          head_v_q <= 1'b0;
        end
      end else if (push) begin
        if (head_v_q) begin
          tail_q   <= in_data_i;
          tail_v_q <= 1'b1;
        end else begin
          out_data_o <= in_data_i;
          head_v_q   <= 1'b1;
        end
      end
    end
  end
endmodule // change_buffer

// ===== design/hub_port_control.v
`timescale 1ns/1ns
`include "hub_consts.vh"

module hub_port_control #(
  parameter PORTS     = 4,
  parameter RESET_CYC = `PORT_RESET_CYC,
  parameter CHIRP_CYC = `CHIRP_CYC
) (
  input  wire             clock_i,
  input  wire             rst_n_i,
  output reg              mem_sclk_o,
  output reg              mem_cs_n_o,
  output reg              mem_mosi_o,
  input  wire             mem_miso_i,
  output reg  [15:0]      vendor_id_o,
  output reg  [15:0]      product_id_o,
  output reg  [15:0]      device_id_o,
  output reg  [3:0]       removable_o,
  input  wire             upstream_bus_power_sense_i,
  input  wire             bus_reset_i,
  input  wire             host_chirp_i,
  input  wire             hub_suspended_i,
  output reg              pullup_o,
  output reg              chirp_o,
  output reg              high_speed_o,
  output reg              resume_upstream_o,
  input  wire             req_valid_i,
  output wire             req_ready_o,
  input  wire [3:0]       req_code_i,
  input  wire [1:0]       req_port_i,
  input  wire [6:0]       req_value_i,
  output reg  [6:0]       address_o,
  output reg  [7:0]       config_value_o,
  input  wire             token_valid_i,
  input  wire [3:0]       token_pid_i,
  input  wire [6:0]       token_addr_i,
  output reg              token_hit_o,
  input  wire [PORTS-1:0] connect_i,
  input  wire [PORTS-1:0] hs_device_i,
  input  wire [PORTS-1:0] nonidle_i,
  input  wire [PORTS-1:0] wake_i,
  input  wire             eof2_i,
  input  wire             packet_end_i,
  input  wire [PORTS-1:0] want_up_i,
  output reg  [PORTS-1:0] se0_drive_o,
  output reg  [PORTS-1:0] power_o,
  output reg  [PORTS-1:0] reset_drive_o,
  output reg  [PORTS-1:0] enabled_o,
  output reg  [PORTS-1:0] suspended_o,
  output reg  [PORTS-1:0] green_o,
  output reg  [PORTS-1:0] via_tt_o,
  output reg  [PORTS-1:0] fs_only_o,
  output reg  [PORTS-1:0] up_path_o,
  output wire             change_valid_o,
  input  wire             change_ready_i,
  output wire [7:0]       change_data_o
);
  localparam S_LOAD   = 3'd0;
  localparam S_NOVBUS = 3'd1;
  localparam S_ATTACH = 3'd2;
  localparam S_CHIRP  = 3'd3;
  localparam S_RUN    = 3'd4;
  localparam LOAD_BITS = `MEM_HDR_BITS + 8 * `MEM_CFG_BYTES;

  reg  [2:0]  state_q;
  reg  [3:0]  div_q;
  reg  [6:0]  bit_q;
  reg  [15:0] hdr_q;
  reg  [7:0]  rx_q;
  reg  [7:0]  code_q;
  reg  [3:0]  usable_q;
  reg  [20:0] chirp_cnt_q;
  reg         manual_ind_q;
  reg  [PORTS-1:0] ind_q;
  wire        spi_tick;
  wire        configured;
  wire        req_take;
  wire        ext_load;
  wire [7:0]  byte_in;
  wire [2:0]  byte_idx;

  assign spi_tick    = (div_q == `SPI_DIV - 1);
  assign configured  = (config_value_o != 8'h00);
  assign req_ready_o = (state_q == S_RUN);
  assign req_take    = req_valid_i & req_ready_o;
  assign ext_load    = (code_q == `LOAD_EXT_A) || (code_q == `LOAD_EXT_B);
  assign byte_in     = {rx_q[6:0], mem_miso_i};
  assign byte_idx    = bit_q[5:3] - 3'd2;

  // serial memory load and upstream attach sequence
  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q      <= S_LOAD;
      div_q        <= 4'h0;
      bit_q        <= 7'h00;
      hdr_q        <= {`MEM_READ_CMD, `MEM_START_ADDR};
      rx_q         <= 8'h00;
      code_q       <= 8'h00;
      usable_q     <= 4'hf;
      removable_o  <= 4'h0;
      vendor_id_o  <= 16'h0000;
      product_id_o <= 16'h0000;
      device_id_o  <= 16'h0000;
      mem_sclk_o   <= 1'b0;
      mem_cs_n_o   <= 1'b1;
      mem_mosi_o   <= 1'b0;
      pullup_o     <= 1'b0;
      chirp_o      <= 1'b0;
      high_speed_o <= 1'b0;
      chirp_cnt_q  <= 21'h0;
      address_o    <= 7'h00;
      config_value_o <= 8'h00;
    end else begin
      div_q <= spi_tick ? 4'h0 : div_q + 4'h1;
      case (state_q)
        S_LOAD: begin
          if (spi_tick) begin
            if (mem_cs_n_o) begin
              mem_cs_n_o <= 1'b0;
              mem_mosi_o <= hdr_q[15];
              hdr_q      <= {hdr_q[14:0], 1'b0};
            end else if (!mem_sclk_o) begin
              mem_sclk_o <= 1'b1;
              rx_q       <= byte_in;
              if (bit_q >= `MEM_HDR_BITS && bit_q[2:0] == 3'h7) begin
                case (byte_idx)
                  `CFG_CODE:   code_q <= byte_in;
                  `CFG_VID_LO: vendor_id_o[7:0]   <= byte_in;
                  `CFG_VID_HI: vendor_id_o[15:8]  <= byte_in;
                  `CFG_PID_LO: product_id_o[7:0]  <= byte_in;
                  `CFG_PID_HI: product_id_o[15:8] <= byte_in;
                  `CFG_DID_LO: device_id_o[7:0]   <= byte_in;
                  `CFG_DID_HI: device_id_o[15:8]  <= byte_in;
                  default: begin
                    if (ext_load) begin
                      usable_q    <= byte_in[3:0];
                      removable_o <= byte_in[7:4];
                    end
                  end
                endcase
              end
            end else begin
              mem_sclk_o <= 1'b0;
              mem_mosi_o <= hdr_q[15];
              hdr_q      <= {hdr_q[14:0], 1'b0};
              bit_q      <= bit_q + 7'h01;
              if (bit_q == LOAD_BITS - 1) begin
                mem_cs_n_o <= 1'b1;
                state_q    <= S_NOVBUS;
              end
            end
          end
        end
        S_NOVBUS: begin
          if (upstream_bus_power_sense_i) begin
            pullup_o <= 1'b1;
            state_q  <= S_ATTACH;
          end
        end
        S_ATTACH, S_RUN: begin
          if (!upstream_bus_power_sense_i) begin
            pullup_o     <= 1'b0;
            high_speed_o <= 1'b0;
            address_o    <= 7'h00;
            config_value_o <= 8'h00;
            state_q      <= S_NOVBUS;
          end else if (bus_reset_i) begin
            address_o      <= 7'h00;
            config_value_o <= 8'h00;
            high_speed_o   <= 1'b0;
            pullup_o       <= 1'b1;
            chirp_o        <= 1'b1;
            chirp_cnt_q    <= 21'h0;
            state_q        <= S_CHIRP;
          end else if (req_take && req_code_i == `REQ_SET_ADDR) begin
            address_o <= req_value_i;
          end else if (req_take && req_code_i == `REQ_SET_CONFIG) begin
            config_value_o <= {1'b0, req_value_i};
          end
        end
        S_CHIRP: begin
          if (chirp_cnt_q == CHIRP_CYC - 1)
            chirp_o <= 1'b0;
          else
            chirp_cnt_q <= chirp_cnt_q + 21'h1;
          if (host_chirp_i && !chirp_o) begin
            high_speed_o <= 1'b1;
            pullup_o     <= 1'b0;
          end
          if (!bus_reset_i) begin
            chirp_o <= 1'b0;
            // full speed stays selected when no answer came
            state_q <= S_RUN;
          end
        end
        default: state_q <= S_LOAD;
      endcase
    end
  end

  // token check runs off its own inputs and the address_o held by the hub machine
  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      token_hit_o <= 1'b0;
    end else begin
      token_hit_o <= token_valid_i && (token_addr_i == address_o) &&
                     (token_pid_i == `PID_TOKEN_OUT ||
                      token_pid_i == `PID_TOKEN_IN ||
                      token_pid_i == `PID_TOKEN_SETUP);
    end
  end

  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      manual_ind_q <= 1'b0;
      ind_q        <= {PORTS{1'b0}};
    end else if (req_take && req_code_i == `REQ_IND_MANUAL) begin
      manual_ind_q <= 1'b1;
      ind_q        <= req_value_i[PORTS-1:0];
    end else if (req_take && req_code_i == `REQ_IND_AUTO) begin
      manual_ind_q <= 1'b0;
    end
  end

  // per-port state; change bits are sticky until the scanner takes them
  reg  [3:0]  chg_q [0:PORTS-1];
  wire [PORTS-1:0] pend;
  reg  [PORTS-1:0] take;
  reg  [1:0]  pick;
  reg         found;
  wire        buf_ready;
  genvar g;

  generate
    for (g = 0; g < PORTS; g = g + 1) begin : port
      reg [20:0] rst_cnt_q;
      reg        armed_q;
      reg        conn_q;
      wire       named;
      wire       usable;
      wire [3:0] chg_set;
      assign named  = req_take && (req_port_i == g);
      assign usable = usable_q[g];
      assign pend[g] = (chg_q[g] != 4'h0);
      assign chg_set[`CHG_CONNECT] = power_o[g] && (conn_q != connect_i[g]);
      assign chg_set[`CHG_ENABLE]  = enabled_o[g] &&
                                     ((armed_q && eof2_i && nonidle_i[g]) ||
                                      !connect_i[g]);
      assign chg_set[`CHG_SUSPEND] = suspended_o[g] && wake_i[g] &&
                                     !hub_suspended_i;
      assign chg_set[`CHG_RESET]   = reset_drive_o[g] &&
                                     (rst_cnt_q == RESET_CYC - 1);

      always @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          chg_q[g]         <= 4'h0;
          rst_cnt_q        <= 21'h0;
          armed_q          <= 1'b0;
          conn_q           <= 1'b0;
          se0_drive_o[g]   <= 1'b1;
          power_o[g]       <= 1'b0;
          reset_drive_o[g] <= 1'b0;
          enabled_o[g]     <= 1'b0;
          suspended_o[g]   <= 1'b0;
        end else begin
          // a new event wins over the scanner taking the old one
          chg_q[g] <= (chg_q[g] & {4{~take[g]}}) | chg_set;
          conn_q   <= power_o[g] & connect_i[g];
          if (!configured || !usable) begin
            se0_drive_o[g]   <= 1'b1;
            power_o[g]       <= 1'b0;
            reset_drive_o[g] <= 1'b0;
            enabled_o[g]     <= 1'b0;
            suspended_o[g]   <= 1'b0;
            armed_q          <= 1'b0;
          end else begin
            se0_drive_o[g] <= 1'b0;
            if (named && req_code_i == `REQ_SET_POWER)
              power_o[g] <= 1'b1;
            else if (named && req_code_i == `REQ_CLR_POWER)
              power_o[g] <= 1'b0;
            if (!power_o[g] || !connect_i[g]) begin
              enabled_o[g]     <= 1'b0;
              reset_drive_o[g] <= 1'b0;
              suspended_o[g]   <= 1'b0;
              armed_q          <= 1'b0;
            end else if (reset_drive_o[g]) begin
              rst_cnt_q <= rst_cnt_q + 21'h1;
              if (rst_cnt_q == RESET_CYC - 1) begin
                reset_drive_o[g] <= 1'b0;
                enabled_o[g]     <= 1'b1;
              end
            end else if (named && req_code_i == `REQ_SET_RESET) begin
              reset_drive_o[g] <= 1'b1;
              enabled_o[g]     <= 1'b0;
              suspended_o[g]   <= 1'b0;
              armed_q          <= 1'b0;
              rst_cnt_q        <= 21'h0;
            end else if (enabled_o[g]) begin
              armed_q <= 1'b1;
              if (armed_q && eof2_i && nonidle_i[g]) begin
                enabled_o[g] <= 1'b0;
                armed_q      <= 1'b0;
              end else if (named && req_code_i == `REQ_CLR_ENABLE) begin
                enabled_o[g]   <= 1'b0;
                suspended_o[g] <= 1'b0;
                armed_q        <= 1'b0;
              end else if (named && req_code_i == `REQ_SET_SUSPEND) begin
                suspended_o[g] <= 1'b1;
              end else if (named && req_code_i == `REQ_CLR_SUSPEND) begin
                suspended_o[g] <= 1'b0;
              end else if (suspended_o[g] && wake_i[g]) begin
                suspended_o[g] <= 1'b0;
              end
            end
          end
        end
      end

      always @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          green_o[g]   <= 1'b0;
          via_tt_o[g]  <= 1'b0;
          fs_only_o[g] <= 1'b0;
          up_path_o[g] <= 1'b0;
        end else begin
          green_o[g]   <= manual_ind_q ? ind_q[g] :
                          (enabled_o[g] & ~suspended_o[g]);
          via_tt_o[g]  <= high_speed_o & enabled_o[g] &
                          ~hs_device_i[g];
          fs_only_o[g] <= ~high_speed_o & hs_device_i[g];
          // path opens only at a packet end; it closes at once when the port is disabled or disconnected
          if (packet_end_i || !up_path_o[g])
            up_path_o[g] <= want_up_i[g] & enabled_o[g] & ~suspended_o[g] &
                            ~(eof2_i & nonidle_i[g]) &
                            connect_i[g];
          if (up_path_o[g] && !(enabled_o[g] && connect_i[g]))
            up_path_o[g] <= 1'b0;
          if (!packet_end_i && !up_path_o[g])
            up_path_o[g] <= 1'b0;
        end
      end
    end
  endgenerate

  // lowest pending port goes first; a full buffer stalls the scanner
  integer i;
  always @* begin
    pick  = 2'd0;
    found = 1'b0;
    take  = {PORTS{1'b0}};
    for (i = PORTS - 1; i >= 0; i = i - 1) begin
      if (pend[i]) begin
        pick  = i[1:0];
        found = 1'b1;
      end
    end
    if (found && buf_ready)
      take[pick] = 1'b1;
  end

  change_buffer #(
    .WIDTH (8)
  ) change_fifo (
    .clock_i     (clock_i),
    .rst_n_i     (rst_n_i),
    .in_valid_i  (found),
    .in_ready_o  (buf_ready),
    .in_data_i   ({2'b00, pick, chg_q[pick]}),
    .out_valid_o (change_valid_o),
    .out_ready_i (change_ready_i),
    .out_data_o  (change_data_o)
  );

  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i)
      resume_upstream_o <= 1'b0;
    else
      resume_upstream_o <= hub_suspended_i &
                           |(suspended_o & wake_i);
  end
endmodule // hub_port_control

// ===== verification/serial_mem_model.sv
`timescale 1ns/1ns
module serial_mem_model #(
  // image values are arbitrary except code d2, which enables the port byte load: code, ids low byte first, port masks
  parameter logic [63:0] IMAGE = 64'hd2_34_12_78_56_bc_9a_5f
) (
  input  wire logic sclk_i,
  input  wire logic cs_n_i,
  input  wire logic mosi_i,
  output logic      miso_o
);
  logic [63:0] shift_q;
  logic [15:0] hdr_q;
  int          bits_q;

  initial miso_o = 1'b0;
  // released line shows the inverse of its last bit, not a held value
  always @(posedge cs_n_i) miso_o <= ~miso_o;
  always @(negedge cs_n_i) begin
    bits_q  <= 0;
    shift_q <= IMAGE;
  end
  always @(posedge sclk_i) begin
    if (!cs_n_i) begin
      bits_q <= bits_q + 1;
      if (bits_q < 16) hdr_q <= {hdr_q[14:0], mosi_i};
    end
  end
  // data follows the command and address, msb first, changed on the fall
  always @(negedge sclk_i) begin
    if (!cs_n_i && bits_q >= 16) begin
      miso_o  <= shift_q[63];
      shift_q <= {shift_q[62:0], 1'b0};
    end
  end
endmodule  // serial_mem_model

// ===== verification/hub_port_checker.sv
`timescale 1ns/1ns
module hub_port_checker #(
  parameter PORTS = 4
) (
  input logic             clock_i,
  input logic             rst_n_i,
  input logic             mem_cs_n_o,
  input logic             upstream_bus_power_sense_i,
  input logic             bus_reset_i,
  input logic             pullup_o,
  input logic             chirp_o,
  input logic             high_speed_o,
  input logic [6:0]       address_o,
  input logic [7:0]       config_value_o,
  input logic [PORTS-1:0] se0_drive_o,
  input logic [PORTS-1:0] power_o,
  input logic             eof2_i,
  input logic [PORTS-1:0] nonidle_i,
  input logic [PORTS-1:0] enabled_o,
  input logic             change_valid_o,
  input logic             change_ready_i,
  input logic [7:0]       change_data_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);

  property p_load_first;
    !mem_cs_n_o |-> !pullup_o;
  endproperty
  a_load_first: assert property (p_load_first)
    else $error("pull-up on during load");
  property p_attach;
    $rose(pullup_o) |-> $past(upstream_bus_power_sense_i);
  endproperty
  a_attach: assert property (p_attach)
    else $error("pull-up without bus power");
  property p_chirp;
    $rose(chirp_o) |-> $past(bus_reset_i);
  endproperty
  a_chirp: assert property (p_chirp)
    else $error("chirp outside bus reset");
  property p_hs;
    $rose(high_speed_o) |-> !pullup_o && !chirp_o;
  endproperty
  a_hs: assert property (p_hs)
    else $error("high speed with pull-up or chirp");
  property p_unconf;
    bus_reset_i [*2] |-> address_o == 7'h00 && config_value_o == 8'h00;
  endproperty
  a_unconf: assert property (p_unconf)
    else $error("address or config kept over bus reset");
  property p_se0;
    (config_value_o == 8'h00) [*2] |-> se0_drive_o == '1 && power_o == '0;
  endproperty
  a_se0: assert property (p_se0)
    else $error("unconfigured port not in SE0 or powered");
  property p_babble;
    eof2_i |=> (enabled_o & $past(enabled_o) & $past(enabled_o, 2)
      & $past(nonidle_i)) == '0;
  endproperty
  a_babble: assert property (p_babble)
    else $error("babbling port left enabled");
  property p_chg_hold;
    change_valid_o && !change_ready_i |=> change_valid_o
      && $stable(change_data_o);
  endproperty
  a_chg_hold: assert property (p_chg_hold)
    else $error("change word dropped while stalled");

  c_hs: cover property ($rose(high_speed_o));
  c_babble: cover property (eof2_i ##1 $fell(enabled_o[0]));
  c_stall: cover property ((change_valid_o && !change_ready_i) [*3]);
endmodule  // hub_port_checker

bind hub_port_control hub_port_checker #(.PORTS(PORTS)) chk_u (.*);

// ===== verification/hub_port_control_tb.sv
`timescale 1ns/1ns
`include "hub_consts.vh"
module hub_port_control_tb;
  localparam int RST_CYC = 20;
  localparam int CHIRP   = 10;
  logic       clock_i, rst_n_i, upstream_bus_power_sense_i, bus_reset_i;
  logic       host_chirp_i, hub_suspended_i, req_valid_i, token_valid_i;
  logic       eof2_i, packet_end_i, change_ready_i;
  logic [3:0] req_code_i, token_pid_i, connect_i, hs_device_i, nonidle_i;
  logic [3:0] wake_i, want_up_i;
  logic [1:0] req_port_i;
  logic [6:0] req_value_i, token_addr_i;
  logic [7:0] d;
  wire        mem_miso_i, mem_sclk_o, mem_cs_n_o, mem_mosi_o, pullup_o;
  wire        chirp_o, high_speed_o, resume_upstream_o, req_ready_o;
  wire        token_hit_o, change_valid_o;
  wire [15:0] vendor_id_o, product_id_o, device_id_o;
  wire [3:0]  removable_o, se0_drive_o, power_o, reset_drive_o, enabled_o;
  wire [3:0]  suspended_o, green_o, via_tt_o, fs_only_o, up_path_o;
  wire [6:0]  address_o;
  wire [7:0]  config_value_o, change_data_o;
  int         fail_count, checked;

  hub_port_control #(.PORTS(4), .RESET_CYC(RST_CYC), .CHIRP_CYC(CHIRP))
    DUT (.*);
  serial_mem_model mem (.sclk_i(mem_sclk_o), .cs_n_i(mem_cs_n_o),
    .mosi_i(mem_mosi_o), .miso_o(mem_miso_i));

  always #4 clock_i = ~clock_i;

  task automatic tick(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask
  task automatic chk(input logic [15:0] got, exp, input string what);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t %s: got %h exp %h", $time, what, got, exp);
    end
  endtask
  // one idle cycle first so valid never rises in the step it fell
  task automatic req(input logic [3:0] c, input logic [1:0] p);
    int n;
    n = 0;
    tick(1);
    while (req_ready_o !== 1'b1 && n < 100) begin
      tick(1);
      n++;
    end
    if (req_ready_o !== 1'b1) begin
      fail_count++;
      $display("[ERR] %0t request not accepted", $time);
    end
    {req_code_i, req_port_i, req_value_i} = {c, p, 7'h01};
    req_valid_i = 1'b1;
    tick(1);
    req_valid_i = 1'b0;
  endtask
  task automatic pop(output logic [7:0] dd);
    int n;
    n = 0;
    do begin
      tick(1);
      n++;
    end while (change_valid_o !== 1'b1 && n < 50);
    if (change_valid_o !== 1'b1) begin
      fail_count++;
      $display("[ERR] %0t no change word offered", $time);
    end
    dd = change_data_o;
    change_ready_i = 1'b1;
    tick(1);
    change_ready_i = 1'b0;
  endtask

  task automatic t_boot();
    int n;
    n = 0;
    tick(10);
    while (mem_cs_n_o !== 1'b1 && n < 3000) begin
      tick(1);
      n++;
    end
    chk(mem.hdr_q, 16'h0300, "read header");
    chk(vendor_id_o, 16'h1234, "vendor id");
    chk(product_id_o, 16'h5678, "product id");
    chk(device_id_o, 16'h9abc, "device id");
    chk(removable_o, 4'h5, "removable mask");
    chk(pullup_o, 1'b0, "pull-up before power");
    upstream_bus_power_sense_i = 1'b1;
    tick(3);
    chk(pullup_o, 1'b1, "pull-up after power");
    bus_reset_i = 1'b1;
    tick(3);
    chk(chirp_o, 1'b1, "chirp in bus reset");
    tick(CHIRP + 2);
    host_chirp_i = 1'b1;
    tick(4);
    chk(high_speed_o, 1'b1, "high speed");
    chk(pullup_o, 1'b0, "pull-up dropped");
    {host_chirp_i, bus_reset_i} = 2'b00;
    $display("test boot done");
  endtask

  task automatic t_enum();
    req(`REQ_SET_ADDR, 2'h0);
    chk(address_o, 7'h01, "address");
    chk(se0_drive_o, 4'hf, "SE0 before config");
    req(`REQ_SET_CONFIG, 2'h0);
    tick(2);
    chk(config_value_o, 8'h01, "config value");
    chk(se0_drive_o, 4'h0, "ports released");
    for (int p = 0; p < 4; p++) begin
      req(`REQ_SET_POWER, p[1:0]);
      chk(power_o, 4'hf >> (3 - p), "port power");
    end
    {token_pid_i, token_addr_i, token_valid_i} = {`PID_TOKEN_IN, 7'h01, 1'b1};
    tick(1);
    chk(token_hit_o, 1'b1, "token match");
    token_addr_i = 7'h02;
    tick(1);
    chk(token_hit_o, 1'b0, "token other address");
    token_valid_i = 1'b0;
    $display("test enum done");
  endtask

  // receiver stalls so the two-entry buffer fills and the rest wait
  task automatic t_changes();
    connect_i = 4'hf;
    tick(10);
    chk(change_valid_o, 1'b1, "change pending");
    for (int p = 0; p < 4; p++) begin
      pop(d);
      chk(d, {2'b00, p[1:0], 4'h1}, "connect change");
    end
    tick(3);
    chk(change_valid_o, 1'b0, "stream empty");
    $display("test changes done");
  endtask

  task automatic t_port();
    hs_device_i = 4'h2;
    for (int p = 0; p < 2; p++) begin
      req(`REQ_SET_RESET, p[1:0]);
      tick(1);
      chk(reset_drive_o[p], 1'b1, "port reset driven");
      tick(RST_CYC + 2);
      chk(enabled_o[p], 1'b1, "port enabled");
      chk(green_o[p], 1'b1, "green lit");
    end
    chk(via_tt_o[1:0], 2'b01, "routing");
    chk(fs_only_o, 4'h0, "no speed limit at high speed");
    req(`REQ_IND_MANUAL, 2'h0);
    tick(1);
    chk(green_o, 4'h1, "host indicator override");
    req(`REQ_IND_AUTO, 2'h0);
    tick(1);
    chk(green_o, 4'h3, "automatic indicator");
    want_up_i = 4'h1;
    tick(3);
    chk(up_path_o, 4'h0, "path before boundary");
    packet_end_i = 1'b1;
    tick(1);
    packet_end_i = 1'b0;
    tick(2);
    chk(up_path_o, 4'h1, "path at boundary");
    for (int p = 0; p < 2; p++) begin
      pop(d);
      chk(d, {2'b00, p[1:0], 4'h8}, "reset change");
    end
    $display("test port done");
  endtask

  task automatic t_suspend();
    req(`REQ_SET_SUSPEND, 2'h1);
    chk(suspended_o, 4'h2, "named port suspended");
    req(`REQ_CLR_SUSPEND, 2'h1);
    chk(suspended_o, 4'h0, "named port resumed");
    req(`REQ_SET_SUSPEND, 2'h1);
    wake_i = 4'h2;
    tick(2);
    wake_i = 4'h0;
    chk(resume_upstream_o, 1'b0, "no upstream resume");
    pop(d);
    chk(d[5:2], 4'h5, "wake reported");
    req(`REQ_SET_SUSPEND, 2'h1);
    {hub_suspended_i, wake_i} = {1'b1, 4'h2};
    tick(1);
    chk(resume_upstream_o, 1'b1, "wake forwarded");
    {hub_suspended_i, wake_i} = 5'h00;
    $display("test suspend done");
  endtask

  task automatic t_disable();
    req(`REQ_CLR_ENABLE, 2'h1);
    chk(enabled_o, 4'h1, "clear enable");
    nonidle_i = 4'h1;
    tick(3);
    chk(enabled_o, 4'h1, "non-idle before EOF2");
    eof2_i = 1'b1;
    tick(1);
    eof2_i = 1'b0;
    tick(1);
    chk(enabled_o, 4'h0, "babble disables");
    chk(up_path_o, 4'h0, "path closed");
    pop(d);
    chk(d, 8'h02, "babble change");
    nonidle_i = 4'h0;
    bus_reset_i = 1'b1;
    tick(CHIRP + 10);
    bus_reset_i = 1'b0;
    tick(3);
    chk(high_speed_o, 1'b0, "full speed fallback");
    chk(config_value_o, 8'h00, "config cleared");
    chk(address_o, 7'h00, "address cleared");
    chk(se0_drive_o, 4'hf, "SE0 again");
    chk(fs_only_o, 4'h2, "fast device held at full speed");
    $display("test disable done");
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    {clock_i, rst_n_i, upstream_bus_power_sense_i, bus_reset_i} = '0;
    {host_chirp_i, hub_suspended_i, req_valid_i, token_valid_i} = '0;
    {eof2_i, packet_end_i, change_ready_i, req_code_i, token_pid_i} = '0;
    {connect_i, hs_device_i, nonidle_i, wake_i, want_up_i} = '0;
    {req_port_i, req_value_i, token_addr_i} = '0;
    fail_count = 0;
    checked = 0;
    tick(5);
    rst_n_i = 1'b1;
    t_boot();
    t_enum();
    t_changes();
    t_port();
    t_suspend();
    t_disable();
    test_done();
  end
  // memory load dominates; the whole run needs far less than this
  initial begin
    #200000;
    fail_count++;
    $display("[ERR] %0t watchdog expired", $time);
    test_done();
  end
endmodule  // hub_port_control_tb
